//--- core/pafo_consts.vh
// constants of the port B alternate function override block
// assumes: included by bare name from the top design file of the block only
`ifndef PAFO_CONSTS_VH
`define PAFO_CONSTS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define PAFO_NPIN 8
`define PAFO_REG_W 8
`define PAFO_DATA_W 32
`define PAFO_ADDR_W 3

// ----------------------------------------------------------------
// register byte offsets (word index is offset / 4)
// ----------------------------------------------------------------
`define PAFO_OFF_DIR 8'h00
`define PAFO_OFF_LATCH 8'h04
`define PAFO_OFF_INPUT 8'h08
`define PAFO_OFF_SFIOC 8'h0C
`define PAFO_OFF_ATSR 8'h10

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PAFO_RST_DIR 8'h00
`define PAFO_RST_LATCH 8'h00
`define PAFO_RST_SFIOC 8'h00
`define PAFO_RST_AS2 1'b0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PAFO_BIT_PUD 2
`define PAFO_BIT_AS2 3

// ----------------------------------------------------------------
// pin numbers on port B
// ----------------------------------------------------------------
`define PAFO_PIN_SS 2
`define PAFO_PIN_TIMER1_COMPARE_B_OUTPUT 2
`define PAFO_PIN_TIMER1_COMPARE_A_OUTPUT 1
`define PAFO_PIN_MOSI 3
`define PAFO_PIN_MISO 4
`define PAFO_PIN_SCK 5
`define PAFO_PIN_OSCIN 6
`define PAFO_PIN_OSCOUT 7

`endif

//--- core/pafo_pin_mux.v
// one pin's override multiplexers: pull-up, driver, value, input enable
// assumes: override signals come straight from the peripherals
`timescale 1ns/1ps
`default_nettype none
module pafo_pin_mux (
  // port register bits
  input wire dir_bit,
  input wire latch_bit,
  input wire global_pullup_disable,
  input wire sleep_clamp,
  // overrides
  input wire pu_oe,
  input wire pu_ov,
  input wire dd_oe,
  input wire dd_ov,
  input wire pv_oe,
  input wire pv_ov,
  input wire die_oe,
  input wire die_ov,
  // pad side
  input wire pad_in,
  output wire drive_en,
  output wire drive_val,
  output wire pullup_en,
  output wire input_en,
  output wire di_tap
);
  // pull-up: default only for dir/latch/pud = 010
  assign pullup_en = pu_oe ? pu_ov : (~dir_bit & latch_bit & ~global_pullup_disable);
  // output driver enable
  assign drive_en = dd_oe ? dd_ov : dir_bit;
  // pin level while driving, low when not driving
  assign drive_val = drive_en & (pv_oe ? pv_ov : latch_bit);
  // digital input enable, clamped in deep sleep
  assign input_en = die_oe ? die_ov : ~sleep_clamp;
  // schmitt output, ahead of any synchroniser
  assign di_tap = pad_in & input_en;
endmodule // pafo_pin_mux
`default_nettype wire

//--- core/pafo_sync.v
// two-stage synchroniser for the pad inputs feeding the input register
// assumes: inputs asynchronous to clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module pafo_sync #(
  parameter W = 8
) (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // data
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_r;
  reg [W-1:0] stable_r;

  // first stage is read only by the second
  always @(posedge clock) begin
    if (sys_rst) begin
      meta_r <= {W{1'b0}};
      stable_r <= {W{1'b0}};
    end else begin
      meta_r <= async_in;
      stable_r <= meta_r;
    end
  end

  assign sync_out = stable_r;
endmodule // pafo_sync
`default_nettype wire

//--- core/pafo_top.v
// port B pin logic with alternate function overrides and register slave
// assumes: Avalon-MM master on the bus side, peripherals drive
// their override controls from the same clock domain
//
// How it works
// - pull-up from override value when enabled, else only for 010 bits.
// - overridden pull-up follows value, ignores direction, latch and disable.
// - driver enable from override value when enabled, else direction bit.
// - overridden driver follows value, ignoring direction bit.
// - driven pin takes override value when value override is enabled.
// - driven pin takes output latch when value override is off.
// - input enable follows sleep state without override.
// - overridden input enable follows override value, ignoring sleep.
// - oscillator analog path goes straight to the pad, both directions.
// - global pull-up disable bit 2 turns off all default pull-ups.
// - with internal RC and async timer, bit 6 becomes oscillator, and bit 7 too unless external clock.
// - clock pins read zero for direction, latch and input bits.
// - bit 6 is oscillator input for all clock sources but internal RC without async timer.
// - SPI slave forces SCK to input; master uses direction bit.
// - SPI master forces MISO to input; slave uses direction bit.
// - SPI slave forces MOSI to input; master uses direction bit.
// - forced SPI input keeps pull-up under output latch control.
`timescale 1ns/1ps
`default_nettype none
`include "pafo_consts.vh"
module pafo_top #(
  parameter NPIN = `PAFO_NPIN,
  parameter AW = `PAFO_ADDR_W
) (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // avalon-mm slave
  input wire [AW-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [`PAFO_DATA_W-1:0] avs_writedata,
  output wire [`PAFO_DATA_W-1:0] avs_readdata,
  output wire avs_waitrequest,
  // clock source and sleep state
  input wire clk_src_intrc,
  input wire clk_src_ext,
  input wire sleep_clamp,
  // spi peripheral
  input wire spi_enable,
  input wire spi_master,
  input wire spi_sck_out,
  input wire spi_slave_out,
  input wire spi_master_out,
  // timer compare outputs
  input wire timer2_compare_enable,
  input wire timer2_compare_output,
  input wire timer1_compare_a_enable,
  input wire timer1_compare_a_output,
  input wire timer1_compare_b_enable,
  input wire timer1_compare_b_output,
  // oscillator amplifier
  input wire osc_amp_drive,
  output wire chip_osc_input,
  output wire timer_osc_input,
  output wire osc_pad_drive,
  output wire osc_pad_drive_en,
  // raw digital inputs to peripherals
  output wire [NPIN-1:0] raw_digital_input_tap,
  // pads
  input wire [NPIN-1:0] pad_in,
  output wire [NPIN-1:0] pad_out,
  output wire [NPIN-1:0] pad_oe,
  output wire [NPIN-1:0] pad_pullup
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg [NPIN-1:0] dir_r;
  reg [NPIN-1:0] latch_r;
  reg [`PAFO_REG_W-1:0] sfioc_r;
  reg as2_r;
  reg [`PAFO_DATA_W-1:0] readdata_r;
  reg waitrequest_r;

  wire global_pullup_disable;
  wire [NPIN-1:0] input_sync;
  wire [NPIN-1:0] drive_en;
  wire [NPIN-1:0] drive_val;
  wire [NPIN-1:0] pullup_en;
  wire [NPIN-1:0] input_en;
  wire [NPIN-1:0] di_tap;

  // override controls, one bit per pin
  reg [NPIN-1:0] pu_oe;
  reg [NPIN-1:0] pu_ov;
  reg [NPIN-1:0] dd_oe;
  reg [NPIN-1:0] dd_ov;
  reg [NPIN-1:0] pv_oe;
  reg [NPIN-1:0] pv_ov;
  reg [NPIN-1:0] die_oe;
  reg [NPIN-1:0] die_ov;

  // clock pin detachment and spi roles
  wire osc_in_pin;
  wire osc_out_pin;
  wire spi_as_master;
  wire spi_as_slave;
  wire [NPIN-1:0] clk_pin_mask;

  assign global_pullup_disable = sfioc_r[`PAFO_BIT_PUD];

  // ----------------------------------------------------------------
  // clock pin selection
  // ----------------------------------------------------------------
  // bit 6 is oscillator input unless internal RC without async timer
  assign osc_in_pin = ~clk_src_intrc | as2_r;
  // bit 7 is oscillator output for crystals, not for external clock
  assign osc_out_pin = ~clk_src_ext & (~clk_src_intrc | as2_r);
  assign spi_as_master = spi_enable & spi_master;
  assign spi_as_slave = spi_enable & ~spi_master;

  // pins whose register bits read as zero
  genvar gm;
  generate
    for (gm = 0; gm < NPIN; gm = gm + 1) begin : g_mask
      if (gm == `PAFO_PIN_OSCIN) begin : g_in
        assign clk_pin_mask[gm] = osc_in_pin;
      end else if (gm == `PAFO_PIN_OSCOUT) begin : g_out
        assign clk_pin_mask[gm] = osc_out_pin;
      end else begin : g_io
        assign clk_pin_mask[gm] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // override generation per alternate function
  // ----------------------------------------------------------------
  // pins without alternate function keep all overrides off
  always @* begin
    pu_oe = {NPIN{1'b0}};
    pu_ov = {NPIN{1'b0}};
    dd_oe = {NPIN{1'b0}};
    dd_ov = {NPIN{1'b0}};
    pv_oe = {NPIN{1'b0}};
    pv_ov = {NPIN{1'b0}};
    die_oe = {NPIN{1'b0}};
    die_ov = {NPIN{1'b0}};
    // oscillator output: detached, no pull-up, no driver, no input
    pu_oe[`PAFO_PIN_OSCOUT] = osc_out_pin;
    dd_oe[`PAFO_PIN_OSCOUT] = osc_out_pin;
    die_oe[`PAFO_PIN_OSCOUT] = osc_out_pin;
    // oscillator input: detached from the port
    pu_oe[`PAFO_PIN_OSCIN] = osc_in_pin;
    dd_oe[`PAFO_PIN_OSCIN] = osc_in_pin;
    die_oe[`PAFO_PIN_OSCIN] = osc_in_pin;
    // sck: input as slave, clock out as master
    pu_oe[`PAFO_PIN_SCK] = spi_as_slave;
    pu_ov[`PAFO_PIN_SCK] = latch_r[`PAFO_PIN_SCK] & ~global_pullup_disable;
    dd_oe[`PAFO_PIN_SCK] = spi_as_slave;
    pv_oe[`PAFO_PIN_SCK] = spi_as_master;
    pv_ov[`PAFO_PIN_SCK] = spi_sck_out;
    // miso: input as master, slave data out as slave
    pu_oe[`PAFO_PIN_MISO] = spi_as_master;
    pu_ov[`PAFO_PIN_MISO] = latch_r[`PAFO_PIN_MISO] & ~global_pullup_disable;
    dd_oe[`PAFO_PIN_MISO] = spi_as_master;
    pv_oe[`PAFO_PIN_MISO] = spi_as_slave;
    pv_ov[`PAFO_PIN_MISO] = spi_slave_out;
    // mosi: input as slave; master data or timer2 compare out
    pu_oe[`PAFO_PIN_MOSI] = spi_as_slave;
    pu_ov[`PAFO_PIN_MOSI] = latch_r[`PAFO_PIN_MOSI] & ~global_pullup_disable;
    dd_oe[`PAFO_PIN_MOSI] = spi_as_slave;
    // compare output leaves direction to software
    pv_oe[`PAFO_PIN_MOSI] = spi_as_master | timer2_compare_enable;
    pv_ov[`PAFO_PIN_MOSI] = spi_as_master ? spi_master_out
                                          : timer2_compare_output;
    // slave select: input as slave; timer1 compare b out
    pu_oe[`PAFO_PIN_SS] = spi_as_slave;
    pu_ov[`PAFO_PIN_SS] = latch_r[`PAFO_PIN_SS] & ~global_pullup_disable;
    dd_oe[`PAFO_PIN_SS] = spi_as_slave;
    pv_oe[`PAFO_PIN_TIMER1_COMPARE_B_OUTPUT] = timer1_compare_b_enable;
    pv_ov[`PAFO_PIN_TIMER1_COMPARE_B_OUTPUT] = timer1_compare_b_output;
    // timer1 compare a out
    pv_oe[`PAFO_PIN_TIMER1_COMPARE_A_OUTPUT] = timer1_compare_a_enable;
    pv_ov[`PAFO_PIN_TIMER1_COMPARE_A_OUTPUT] = timer1_compare_a_output;
  end

  // ----------------------------------------------------------------
  // per-pin multiplexers
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp = gp + 1) begin : g_pin
      pafo_pin_mux u_mux (
        .dir_bit(dir_r[gp]),
        .latch_bit(latch_r[gp]),
        .global_pullup_disable(global_pullup_disable),
        .sleep_clamp(sleep_clamp),
        .pu_oe(pu_oe[gp]),
        .pu_ov(pu_ov[gp]),
        .dd_oe(dd_oe[gp]),
        .dd_ov(dd_ov[gp]),
        .pv_oe(pv_oe[gp]),
        .pv_ov(pv_ov[gp]),
        .die_oe(die_oe[gp]),
        .die_ov(die_ov[gp]),
        .pad_in(pad_in[gp]),
        .drive_en(drive_en[gp]),
        .drive_val(drive_val[gp]),
        .pullup_en(pullup_en[gp]),
        .input_en(input_en[gp]),
        .di_tap(di_tap[gp])
      );
    end
  endgenerate

  // pad controls change with the overrides, without a clock edge
  assign pad_oe = drive_en;
  assign pad_out = drive_val;
  assign pad_pullup = pullup_en;
  // raw input tap, unsynchronised; peripherals add their own
  assign raw_digital_input_tap = di_tap;

  // ----------------------------------------------------------------
  // oscillator analog path
  // ----------------------------------------------------------------
  // pad bypasses the input gating in both directions
  assign chip_osc_input = pad_in[`PAFO_PIN_OSCIN] & osc_in_pin;
  assign timer_osc_input = pad_in[`PAFO_PIN_OSCIN] & as2_r;
  assign osc_pad_drive = osc_amp_drive & osc_out_pin;
  assign osc_pad_drive_en = osc_out_pin;

  // ----------------------------------------------------------------
  // input register synchroniser
  // ----------------------------------------------------------------
  pafo_sync #(
    .W(NPIN)
  ) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in(di_tap),
    .sync_out(input_sync)
  );

  // ----------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------
  // word index match for a byte offset
  function hit;
    input [AW-1:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off[AW+1:2]);
    end
  endfunction

  wire wr_go;
  wire rd_go;
  wire lane0;
  reg [`PAFO_REG_W-1:0] rd_val;

  // write lands at the edge the master sees waitrequest low
  assign wr_go = avs_write & ~waitrequest_r;
  // read data captured one edge earlier, standing at that edge
  assign rd_go = avs_read & waitrequest_r;
  assign lane0 = avs_byteenable[0];

  // read selection, clock pins masked to zero
  always @* begin
    rd_val = {`PAFO_REG_W{1'b0}};
    if (hit(avs_address, `PAFO_OFF_DIR)) begin
      rd_val = dir_r & ~clk_pin_mask;
    end else if (hit(avs_address, `PAFO_OFF_LATCH)) begin
      rd_val = latch_r & ~clk_pin_mask;
    end else if (hit(avs_address, `PAFO_OFF_INPUT)) begin
      rd_val = input_sync & ~clk_pin_mask;
    end else if (hit(avs_address, `PAFO_OFF_SFIOC)) begin
      rd_val = sfioc_r;
    end else if (hit(avs_address, `PAFO_OFF_ATSR)) begin
      rd_val[`PAFO_BIT_AS2] = as2_r;
    end
  end

  // one wait cycle, then a single accept cycle
  always @(posedge clock) begin
    if (sys_rst) begin
      waitrequest_r <= 1'b1;
    end else if ((avs_read | avs_write) & waitrequest_r) begin
      waitrequest_r <= 1'b0;
    end else begin
      waitrequest_r <= 1'b1;
    end
  end

  // read data register
  always @(posedge clock) begin
    if (sys_rst) begin
      readdata_r <= {`PAFO_DATA_W{1'b0}};
    end else if (rd_go) begin
      readdata_r <= {{(`PAFO_DATA_W-`PAFO_REG_W){1'b0}}, rd_val};
    end
  end

  // register writes on byte lane 0; unmapped writes ignored
  always @(posedge clock) begin
    if (sys_rst) begin
      dir_r <= `PAFO_RST_DIR;
      latch_r <= `PAFO_RST_LATCH;
      sfioc_r <= `PAFO_RST_SFIOC;
      as2_r <= `PAFO_RST_AS2;
    end else if (wr_go & lane0) begin
      if (hit(avs_address, `PAFO_OFF_DIR)) begin
        dir_r <= avs_writedata[NPIN-1:0];
      end
      if (hit(avs_address, `PAFO_OFF_LATCH)) begin
        latch_r <= avs_writedata[NPIN-1:0];
      end
      if (hit(avs_address, `PAFO_OFF_SFIOC)) begin
        sfioc_r <= avs_writedata[`PAFO_REG_W-1:0];
      end
      if (hit(avs_address, `PAFO_OFF_ATSR)) begin
        as2_r <= avs_writedata[`PAFO_BIT_AS2];
      end
    end
  end

  assign avs_readdata = readdata_r;
  assign avs_waitrequest = waitrequest_r;

endmodule // pafo_top
`default_nettype wire

//--- testbench/pafo_assertions.sv
// checker of pad override relations seen at the top ports
// assumes: bound into pafo_top, one clock domain, reset active high
`timescale 1ns/1ps
`default_nettype none
module pafo_checker (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // bus and controls
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic clk_src_intrc,
  input wire logic sleep_clamp,
  input wire logic spi_enable,
  input wire logic spi_master,
  input wire logic spi_sck_out,
  input wire logic timer1_compare_a_enable,
  input wire logic timer1_compare_a_output,
  // pads and taps
  input wire logic chip_osc_input,
  input wire logic [7:0] raw_digital_input_tap,
  input wire logic [7:0] pad_in,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // pin relations
  // ------------------------------------------------------------
  pu_drive_excl_a: assert property (!(|(pad_pullup[0] & pad_oe[0])))
    else $error("pull-up on a driven plain pin");
  idle_low_a: assert property (!pad_oe[0] |-> !pad_out[0])
    else $error("undriven pin shows a level");
  slave_inputs_a: assert property ((spi_enable && !spi_master) |->
    (!pad_oe[5] && !pad_oe[3])) else $error("slave pins not forced in");
  master_miso_a: assert property ((spi_enable && spi_master) |->
    !pad_oe[4]) else $error("master input pin driven");
  sck_value_a: assert property ((spi_enable && spi_master && pad_oe[5])
    |-> pad_out[5] == spi_sck_out) else $error("clock value not passed");
  cmp_value_a: assert property ((timer1_compare_a_enable && pad_oe[1])
    |-> pad_out[1] == timer1_compare_a_output) else $error("compare lost");
  sleep_tap_a: assert property (raw_digital_input_tap[1:0] ==
    (sleep_clamp ? 2'h0 : pad_in[1:0])) else $error("input tap wrong");
  osc_pin_a: assert property (!clk_src_intrc |-> (!pad_oe[6] &&
    !pad_pullup[6] && !raw_digital_input_tap[6] &&
    chip_osc_input == pad_in[6])) else $error("oscillator pin misused");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("accept longer than one cycle");
  accept_cause_a: assert property ($fell(avs_waitrequest) |->
    $past(avs_read || avs_write)) else $error("accept without request");
endmodule // pafo_checker

bind pafo_top pafo_checker chk (
  .clock(clock),
  .sys_rst(sys_rst),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .clk_src_intrc(clk_src_intrc),
  .sleep_clamp(sleep_clamp),
  .spi_enable(spi_enable),
  .spi_master(spi_master),
  .spi_sck_out(spi_sck_out),
  .timer1_compare_a_enable(timer1_compare_a_enable),
  .timer1_compare_a_output(timer1_compare_a_output),
  .chip_osc_input(chip_osc_input),
  .raw_digital_input_tap(raw_digital_input_tap),
  .pad_in(pad_in),
  .pad_out(pad_out),
  .pad_oe(pad_oe),
  .pad_pullup(pad_pullup)
);
`default_nettype wire

//--- testbench/pafo_periph.sv
// model of the peripherals that source the pin overrides
// assumes: same clock as the pin block, modes set by the bench
`timescale 1ns/1ps
`default_nettype none
module pafo_periph (
  // clock and modes
  input wire logic clock,
  input wire logic [1:0] spi_mode,
  input wire logic timer_on,
  input wire logic sck_tap,
  // override sources
  output logic spi_enable,
  output logic spi_master,
  output logic spi_sck_out,
  output logic spi_slave_out,
  output logic spi_master_out,
  output logic tmr_en,
  output logic [2:0] tmr_out,
  output logic osc_amp_drive,
  output logic sck_seen
);
  logic [3:0] cnt_r = 4'h0;
  logic [1:0] sync_r = 2'h0;
  // pattern source and own synchroniser of the raw tap
  always @(posedge clock) begin
    cnt_r <= cnt_r + 4'h1;
    sync_r <= {sync_r[0], sck_tap};
  end
  // each function makes its own enables and values
  assign spi_enable = spi_mode != 2'h0;
  assign spi_master = spi_mode == 2'h2;
  assign spi_sck_out = spi_master & cnt_r[0];
  assign spi_slave_out = ~cnt_r[1];
  assign spi_master_out = cnt_r[2];
  assign tmr_en = timer_on;
  assign tmr_out = cnt_r[3:1];
  assign osc_amp_drive = cnt_r[0];
  assign sck_seen = sync_r[1];
endmodule // pafo_periph
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench of the port B override block
// assumes: pafo_top from core, peripheral model, bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic intrc = 1'b1;
  logic ext = 1'b1;
  logic sleep = 1'b0;
  logic [1:0] spi_mode = 2'h0;
  logic timer_on = 1'b0;
  logic spe, mstr, sck_o, sl_o, ms_o, tmr_en, osc_amp, sck_seen;
  logic [2:0] tmr_out;
  logic chip_osc, tosc, osc_drv, osc_drv_en;
  logic [7:0] tap, pad_out, pad_oe, pad_pullup;
  logic [7:0] ext_r = 8'h5A;
  wire logic [7:0] pad_in;
  int error_cnt = 0;
  int comparisons = 0;
  // pad level: driver, else pull-up, else outside level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & (pad_pullup | ext_r));
  // clock
  initial begin
    forever #5 clock = ~clock;
  end
  pafo_periph peri (.clock(clock), .spi_mode(spi_mode),
    .timer_on(timer_on), .sck_tap(tap[5]), .spi_enable(spe),
    .spi_master(mstr), .spi_sck_out(sck_o), .spi_slave_out(sl_o),
    .spi_master_out(ms_o), .tmr_en(tmr_en), .tmr_out(tmr_out),
    .osc_amp_drive(osc_amp), .sck_seen(sck_seen));
  pafo_top uut (.clock(clock), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'hF),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .clk_src_intrc(intrc),
    .clk_src_ext(ext), .sleep_clamp(sleep), .spi_enable(spe),
    .spi_master(mstr), .spi_sck_out(sck_o), .spi_slave_out(sl_o),
    .spi_master_out(ms_o), .timer2_compare_enable(tmr_en),
    .timer2_compare_output(tmr_out[2]), .timer1_compare_a_enable(tmr_en),
    .timer1_compare_a_output(tmr_out[0]), .timer1_compare_b_enable(tmr_en),
    .timer1_compare_b_output(tmr_out[1]), .osc_amp_drive(osc_amp),
    .chip_osc_input(chip_osc), .timer_osc_input(tosc),
    .osc_pad_drive(osc_drv), .osc_pad_drive_en(osc_drv_en),
    .raw_digital_input_tap(tap), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup(pad_pullup));
  // compare and count
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (act !== exp) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: got %h want %h", $time, act, exp);
    end
  endtask
  // one Avalon access, entered just after a rising edge
  task automatic bus(input logic wr, input logic [2:0] a,
      input logic [7:0] d, output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clock);
      n = n + 1;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    // a hung slave counts as a mismatch and ends the run
    if (avs_waitrequest !== 1'b0) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: bus access timed out", $time);
      stop_test();
    end else begin
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  // reset values and unmapped word
  task automatic t_regs;
    rd(3'h0, 32'h0);
    rd(3'h1, 32'h0);
    rd(3'h3, 32'h0);
    rd(3'h4, 32'h0);
    wr(3'h5, 8'hFF);
    rd(3'h5, 32'h0);
    chk(pad_oe, 8'h00);
    $display("test regs done");
  endtask
  // plain pins, default pull-up and global disable
  task automatic t_pins;
    wr(3'h0, 8'h0F);
    wr(3'h1, 8'hC3);
    chk(pad_oe, 8'h0F);
    chk(pad_out, 8'h03);
    chk(pad_pullup, 8'hC0);
    chk(tap, 8'hD3);
    // input register lags the pad by two edges
    @(posedge clock);
    rd(3'h2, 32'hD3);
    sleep <= 1'b1;
    @(negedge clock);
    chk(tap, 8'h00);
    @(posedge clock);
    sleep <= 1'b0;
    wr(3'h3, 8'h04);
    chk(pad_pullup, 8'h00);
    rd(3'h3, 32'h04);
    wr(3'h3, 8'h00);
    $display("test pins done");
  endtask
  // spi slave then master forcing
  task automatic t_spi;
    logic [1:0] s;
    s = 2'h0;
    wr(3'h0, 8'hFF);
    wr(3'h1, 8'h38);
    spi_mode <= 2'h1;
    @(negedge clock);
    chk(pad_oe, 8'hD3);
    chk(pad_pullup, 8'h28);
    chk(pad_out[4], sl_o);
    @(posedge clock);
    // global disable also drops the forced-input pull-ups
    wr(3'h3, 8'h04);
    chk(pad_pullup, 8'h00);
    wr(3'h3, 8'h00);
    spi_mode <= 2'h2;
    repeat (2) begin
      @(negedge clock);
      s = {s[0], sck_o};
      chk(pad_oe, 8'hEF);
      chk(pad_pullup, 8'h10);
      chk({pad_out[5], pad_out[3]}, {sck_o, ms_o});
    end
    @(posedge clock);
    spi_mode <= 2'h0;
    @(negedge clock);
    chk(pad_pullup, 8'h00);
    // model's own synchroniser shows the clock pad two edges late
    chk(sck_seen, s[1]);
    @(posedge clock);
    $display("test spi done");
  endtask
  // timer compare outputs need the direction bit
  task automatic t_timer;
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h0E);
    timer_on <= 1'b1;
    repeat (2) begin
      @(negedge clock);
      chk(pad_out[3:1], tmr_out);
    end
    @(posedge clock);
    wr(3'h0, 8'h06);
    chk({pad_oe[3], pad_out[3]}, 2'h0);
    timer_on <= 1'b0;
    $display("test timer done");
  endtask
  // oscillator pins
  task automatic t_clock;
    wr(3'h0, 8'hFF);
    wr(3'h1, 8'hFF);
    intrc <= 1'b0;
    @(negedge clock);
    chk({pad_oe[6], tap[6], chip_osc}, 3'h1);
    @(posedge clock);
    rd(3'h0, 32'hBF);
    rd(3'h1, 32'hBF);
    rd(3'h2, 32'hBF);
    intrc <= 1'b1;
    ext <= 1'b0;
    wr(3'h4, 8'h08);
    @(negedge clock);
    chk({pad_oe[7:6], tosc}, 3'h1);
    chk({osc_drv, osc_drv_en}, {osc_amp, 1'b1});
    @(posedge clock);
    rd(3'h0, 32'h3F);
    wr(3'h4, 8'h00);
    ext <= 1'b1;
    $display("test clock done");
  endtask
  // closing report
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_regs();
    t_pins();
    t_spi();
    t_timer();
    t_clock();
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
